// ===== crpc_ctrl.sv
// Clock divider, reset sequencer and Stop/Idle power-down controller.
// Assumes the CPU and peripherals run on mclk_i gated by the enables here.
`timescale 1ns/10ps
module crpc_ctrl #(
	parameter int unsigned STAB_CYCLES = crpc_pkg::STAB_CYC
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Pins from outside
	input wire logic ext_reset_pin_low_n_i,
	input wire logic wake_irq_line_a_i,
	input wire logic wake_irq_line_b_i,
	input wire logic test_pin_i,
	// CPU side
	input wire logic [7:0] cpu_op_i,
	input wire logic cpu_op_valid_i,
	input wire logic irq_any_i,
	// Avalon-MM slave
	input wire logic [crpc_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Clock enables
	output logic osc_run_o,
	output logic cpu_clk_en_o,
	output logic periph_clk_en_o,
	// Reset effects and wake outputs
	output logic cpu_rst_o,
	output logic periph_rst_o,
	output logic ints_disabled_o,
	output logic wdt_enable_o,
	output logic ports_input_o,
	output logic pc_load_o,
	output logic [15:0] pc_vector_o,
	output logic fetch_go_o,
	output logic irq_wake_o,
	output logic rom_int_en_o,
	output logic ext_if_cfg_o,
	output logic [1:0] wake_irq_o
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int NPIN = 4; // Reset, wake a, wake b, test
	localparam logic [NPIN-1:0] PIN_RST = 4'h0; // Reset pin reads asserted, wake and test idle low
	logic [NPIN-1:0] pin_raw; // Raw pins
	logic [NPIN-1:0] pin_s1; // First stage, read only by second
	logic [NPIN-1:0] pin_s2; // Second stage
	logic [NPIN-1:0] pin_s3; // Third stage
	logic [NPIN-1:0] pin_ok; // Agreed level
	assign pin_raw = {test_pin_i, wake_irq_line_b_i, wake_irq_line_a_i, ext_reset_pin_low_n_i};

	// Three stage flops and an output flop per pin, accept when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_sync
			always_ff @(posedge mclk_i)
			begin
				if (sys_rst_i)
				begin
					pin_s1[gi] <= PIN_RST[gi];
					pin_s2[gi] <= PIN_RST[gi];
					pin_s3[gi] <= PIN_RST[gi];
					pin_ok[gi] <= PIN_RST[gi];
				end
				else
				begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					if (pin_s2[gi] == pin_s3[gi])
						pin_ok[gi] <= pin_s3[gi];
				end
			end
		end
	endgenerate

	logic rst_held; // Filtered pin reset active
	logic wake_any; // Either wake line high
	assign rst_held = ~pin_ok[0];
	assign wake_any = pin_ok[1] | pin_ok[2];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] clk_ctl; // Divider control
	logic [7:0] stop_ctl; // Stop control
	crpc_pkg::crpc_state_t state; // Sequencer state
	logic [1:0] div_sel; // Divider select field
	logic bus_ack; // Second cycle of an access
	logic [7:0] addr_idx; // Register index
	logic addr_word; // Address is word aligned
	logic wr_fire; // Write taking effect
	logic stop_wake_irq; // Stop left through a wake line
	assign div_sel = clk_ctl[crpc_pkg::CLK_DIV_MSB:crpc_pkg::CLK_DIV_LSB];
	assign addr_idx = avs_address_i[crpc_pkg::ADDR_W-1:2];
	assign addr_word = (avs_address_i[1:0] == 2'h0);
	assign wr_fire = avs_write_i & bus_ack & avs_byteenable_i[0] & addr_word;
	assign stop_wake_irq = (state == crpc_pkg::ST_STOP) & wake_any & ~rst_held;

	// Every access waits one cycle then completes
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack;

	// Acknowledge flop
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			bus_ack <= 1'b0;
		else
			bus_ack <= (avs_read_i | avs_write_i) & ~bus_ack;
	end

	// Clock control register, only bits 7, 4 and 3 stored
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || rst_held)
			clk_ctl <= crpc_pkg::CLK_CTL_RST;
		else if (wr_fire && addr_idx == crpc_pkg::IDX_CLK_CTL)
			clk_ctl <= avs_writedata_i[7:0] & crpc_pkg::CLK_CTL_MASK;
	end

	// Stop control register, cleared on reset and on wake from Stop
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || rst_held || stop_wake_irq)
			stop_ctl <= crpc_pkg::STOP_CTL_RST;
		else if (wr_fire && addr_idx == crpc_pkg::IDX_STOP_CTL)
			stop_ctl <= avs_writedata_i[7:0];
	end

	// Read data, unmapped or misaligned reads give zero
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			avs_readdata_o <= 32'h0;
		else if (avs_read_i && !bus_ack)
		begin
			if (!addr_word)
				avs_readdata_o <= 32'h0;
			else if (addr_idx == crpc_pkg::IDX_CLK_CTL)
				avs_readdata_o <= {24'h0, clk_ctl};
			else if (addr_idx == crpc_pkg::IDX_STOP_CTL)
				avs_readdata_o <= {24'h0, stop_ctl};
			else if (addr_idx == crpc_pkg::IDX_STATUS)
				avs_readdata_o <= {27'h0, rst_held, 1'b0, state};
			else
				avs_readdata_o <= 32'h0;
		end
	end

	// ----------------------------------------
	// CPU clock divider
	// ----------------------------------------
	logic [4:0] ratio; // Cycles per CPU tick
	logic [4:0] div_cnt; // Divider count
	logic div_tick; // Divided rate pulse

	// Select decode
	always_comb
	begin
		case (div_sel)
			crpc_pkg::DIV_SEL_16: ratio = crpc_pkg::RATIO_16;
			crpc_pkg::DIV_SEL_8: ratio = crpc_pkg::RATIO_8;
			crpc_pkg::DIV_SEL_2: ratio = crpc_pkg::RATIO_2;
			default: ratio = crpc_pkg::RATIO_1;
		endcase
	end

	assign div_tick = osc_run_o && (div_cnt >= ratio - 5'h01);

	// Free count, frozen with the oscillator
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			div_cnt <= 5'h0;
		else if (!osc_run_o)
			div_cnt <= div_cnt;
		else if (div_tick)
			div_cnt <= 5'h0;
		else
			div_cnt <= div_cnt + 5'h01;
	end

	// ----------------------------------------
	// Reset and power-down sequencer
	// ----------------------------------------
	logic [16:0] stab_cnt; // Stabilisation count
	logic stab_done; // Interval complete
	logic op_stop; // Stop instruction executed
	logic op_idle; // Idle instruction executed
	assign stab_done = (stab_cnt == 17'(STAB_CYCLES - 1));
	assign op_stop = cpu_op_valid_i && cpu_op_i == crpc_pkg::OP_STOP;
	assign op_idle = cpu_op_valid_i && cpu_op_i == crpc_pkg::OP_IDLE;

	// State transitions
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			state <= crpc_pkg::ST_RESET;
		else if (rst_held)
			state <= crpc_pkg::ST_RESET;
		else
		begin
			case (state)
				crpc_pkg::ST_RESET: state <= crpc_pkg::ST_STAB;
				crpc_pkg::ST_STAB:
					if (stab_done)
						state <= crpc_pkg::ST_RUN;
				crpc_pkg::ST_RUN:
					if (op_stop)
						state <= crpc_pkg::ST_STOP;
					else if (op_idle)
						state <= crpc_pkg::ST_IDLE;
				crpc_pkg::ST_IDLE:
					if (irq_any_i || wake_any)
						state <= crpc_pkg::ST_RUN;
				crpc_pkg::ST_STOP:
					if (wake_any)
						state <= crpc_pkg::ST_STAB;
				default: state <= crpc_pkg::ST_RESET;
			endcase
		end
	end

	// Stabilisation counter, restarted on each entry
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || state != crpc_pkg::ST_STAB)
			stab_cnt <= 17'h0;
		else if (!stab_done)
			stab_cnt <= stab_cnt + 17'h1;
	end

	// Remember whether the wait follows a Stop wake
	logic from_stop; // Wait entered from Stop
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || rst_held)
			from_stop <= 1'b0;
		else if (stop_wake_irq)
			from_stop <= 1'b1;
		else if (state == crpc_pkg::ST_RUN)
			from_stop <= 1'b0;
	end

	// ----------------------------------------
	// Clock enables
	// ----------------------------------------
	// Oscillator stops only in Stop
	assign osc_run_o = (state != crpc_pkg::ST_STOP);
	// CPU gets ticks only when running, so Idle keeps its state
	assign cpu_clk_en_o = div_tick && state == crpc_pkg::ST_RUN;
	// Timers and interrupt logic keep ticking in Idle
	assign periph_clk_en_o = div_tick && state != crpc_pkg::ST_STOP;

	// ----------------------------------------
	// Reset effects and wake pulses
	// ----------------------------------------
	// Level outputs during reset
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			cpu_rst_o <= 1'b1;
			periph_rst_o <= 1'b1;
			ints_disabled_o <= 1'b1;
			wdt_enable_o <= 1'b1;
			ports_input_o <= 1'b1;
		end
		else
		begin
			cpu_rst_o <= rst_held || state == crpc_pkg::ST_RESET;
			periph_rst_o <= rst_held;
			ints_disabled_o <= rst_held;
			wdt_enable_o <= rst_held ? 1'b1 : wdt_enable_o;
			ports_input_o <= rst_held;
		end
	end

	// Vector load level, first fetch and interrupt resume pulses
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			pc_load_o <= 1'b0;
			pc_vector_o <= crpc_pkg::RESET_VECTOR;
			fetch_go_o <= 1'b0;
			irq_wake_o <= 1'b0;
		end
		else
		begin
			pc_load_o <= rst_held;
			pc_vector_o <= crpc_pkg::RESET_VECTOR;
			fetch_go_o <= state == crpc_pkg::ST_STAB && stab_done && !from_stop && !rst_held;
			irq_wake_o <= !rst_held && ((state == crpc_pkg::ST_IDLE && (irq_any_i || wake_any))
				|| (state == crpc_pkg::ST_STAB && stab_done && from_stop));
		end
	end

	// Memory mode and filtered wake lines
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			rom_int_en_o <= 1'b0;
			ext_if_cfg_o <= 1'b0;
			wake_irq_o <= 2'h0;
		end
		else
		begin
			if (rst_held)
				rom_int_en_o <= ~pin_ok[3];
			ext_if_cfg_o <= 1'b0;
			wake_irq_o <= pin_ok[2:1];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	// Cycles since the last divided tick
	logic [5:0] gap; // Helper gap counter
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || div_tick)
			gap <= 6'h01;
		else if (osc_run_o)
			gap <= gap + 6'h01; // Frozen with the divider count in Stop
	end

	a_div_ratio: assert property (div_tick && $past(div_tick) == 1'b0 && $stable(div_sel)
		&& $past(osc_run_o) |-> gap == {1'b0, ratio})
		else $error("divider gap wrong");
	a_stop_halt: assert property (state == crpc_pkg::ST_STOP |->
		!osc_run_o && !cpu_clk_en_o && !periph_clk_en_o)
		else $error("clock runs in stop");
	a_stop_hold: assert property (state == crpc_pkg::ST_STOP && !wake_any && !rst_held
		|=> state == crpc_pkg::ST_STOP)
		else $error("stop left without cause");
	a_idle_gate: assert property (state == crpc_pkg::ST_IDLE |->
		!cpu_clk_en_o && osc_run_o && periph_clk_en_o == div_tick)
		else $error("idle gating wrong");
	a_idle_exit: assert property (state == crpc_pkg::ST_IDLE && irq_any_i && !rst_held
		|=> state == crpc_pkg::ST_RUN ##0 irq_wake_o)
		else $error("idle not released");
	a_reset_regs: assert property (rst_held |=> clk_ctl == 8'h00 && stop_ctl == 8'h00
		&& ints_disabled_o && ports_input_o && wdt_enable_o && pc_load_o)
		else $error("reset defaults missing");
	a_reset_hold: assert property (rst_held [*2] |-> cpu_rst_o && state == crpc_pkg::ST_RESET)
		else $error("cpu not held");
	a_fetch_wait: assert property (fetch_go_o |-> $past(state) == crpc_pkg::ST_STAB
		&& $past(stab_cnt) == 17'(STAB_CYCLES - 1))
		else $error("fetch before stabilised");
	a_wake_div: assert property (state == crpc_pkg::ST_STOP && wake_any && !rst_held
		|=> $stable(clk_ctl) && stop_ctl == 8'h00)
		else $error("wake changed divider");
	a_unused_zero: assert property ((clk_ctl & ~crpc_pkg::CLK_CTL_MASK) == 8'h00)
		else $error("unused bits set");

	c_idle_wake: cover property (state == crpc_pkg::ST_IDLE ##1 state == crpc_pkg::ST_RUN);
	c_stop_wake: cover property (state == crpc_pkg::ST_STOP ##1 state == crpc_pkg::ST_STAB);
	c_boot: cover property (fetch_go_o);
	c_fast_div: cover property (div_sel == crpc_pkg::DIV_SEL_1 && cpu_clk_en_o);
endmodule : crpc_ctrl

// ===== crpc_ctrl_tb.sv
// Self-checking bench for the clock, reset and power-down controller.
// Assumes crpc_pkg, crpc_ctrl and crpc_pin_model compiled first.
`timescale 1ns/10ps
module crpc_ctrl_tb;
	localparam int STAB = 20; // Shortened stabilisation count
	localparam int LIMIT = 20000; // Timeout in cycles
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic pin_n, wake_a, wake_b, test_pin;
	logic [7:0] cpu_op = 8'h00;
	logic op_valid = 1'b0;
	logic irq_any = 1'b0;
	logic [crpc_pkg::ADDR_W-1:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] be = 4'hF;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic waitreq, osc_run, cpu_en, per_en, cpu_rst, per_rst, ints_dis, wdt_en;
	logic ports_in, pc_load, fetch_go, irq_wake, rom_en, ext_cfg;
	logic [15:0] pc_vec;
	logic [1:0] wake_lv;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;

	crpc_pin_model #(.HOLD_CYC(STAB)) crpc_pin_model_i (.mclk_i(mclk_i),
		.ext_reset_pin_low_n_o(pin_n), .wake_irq_line_a_o(wake_a),
		.wake_irq_line_b_o(wake_b), .test_pin_o(test_pin));

	crpc_ctrl #(.STAB_CYCLES(STAB)) crpc_ctrl_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.ext_reset_pin_low_n_i(pin_n), .wake_irq_line_a_i(wake_a),
		.wake_irq_line_b_i(wake_b), .test_pin_i(test_pin), .cpu_op_i(cpu_op),
		.cpu_op_valid_i(op_valid), .irq_any_i(irq_any), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
		.osc_run_o(osc_run), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
		.cpu_rst_o(cpu_rst), .periph_rst_o(per_rst), .ints_disabled_o(ints_dis),
		.wdt_enable_o(wdt_en), .ports_input_o(ports_in), .pc_load_o(pc_load),
		.pc_vector_o(pc_vec), .fetch_go_o(fetch_go), .irq_wake_o(irq_wake),
		.rom_int_en_o(rom_en), .ext_if_cfg_o(ext_cfg), .wake_irq_o(wake_lv));

	// 50 MHz clock
	initial
	begin
		forever #10 mclk_i = ~mclk_i;
	end

	// Hang guard
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			bad_count++;
			close_out();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task close_out;
		$display("mismatches %0d comparisons %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk

	// One Avalon access, held until waitrequest is sampled low at a rising edge
	task bus(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk_i);
		addr <= {idx, 2'b00};
		wr <= w;
		rd <= ~w;
		wdata <= d;
		@(posedge mclk_i);
		while (waitreq !== 1'b0)
			@(posedge mclk_i);
		// Read data taken and request dropped at the accepting edge
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task wr8(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, {24'h0, d}, q);
	endtask : wr8

	task rd8(input logic [7:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, idx, 32'h0, q);
		chk(q, exp, what);
	endtask : rd8

	function automatic logic pick(input int k);
		case (k)
			0: return fetch_go;
			1: return irq_wake;
			2: return cpu_en;
			default: return per_en;
		endcase
	endfunction : pick

	// Cycles until the chosen output is high
	task wait_for(input int k, input int max, output int n);
		n = 0;
		do
		begin
			@(negedge mclk_i);
			n++;
		end
		while (pick(k) !== 1'b1 && n < max);
	endtask : wait_for

	// Pulses of the chosen output over a number of cycles
	task cnt(input int k, input int cycles, output int c);
		c = 0;
		repeat (cycles)
		begin
			@(negedge mclk_i);
			if (pick(k) === 1'b1)
				c++;
		end
	endtask : cnt

	task op(input logic [7:0] code);
		@(posedge mclk_i);
		cpu_op <= code;
		op_valid <= 1'b1;
		@(posedge mclk_i);
		op_valid <= 1'b0;
	endtask : op

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		int n;
		int c;
		int ratio [4];
		ratio = '{16, 8, 2, 1};
		repeat (3) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		// Pin reset at start-up and in mid-run, and its release
		for (int k = 0; k < 2; k++)
		begin
			crpc_pin_model_i.test_set(1'(k));
			crpc_pin_model_i.pin_set(1'b0);
			repeat (10) @(posedge mclk_i);
			rd8(crpc_pkg::IDX_STATUS, 32'h10, "status in reset");
			chk({cpu_rst, per_rst, ints_dis, ports_in, wdt_en}, 32'h1F, "reset levels");
			chk(pc_vec, 32'h0100, "vector");
			chk(pc_load, 32'h1, "vector load");
			crpc_pin_model_i.pin_set(1'b1);
			wait_for(0, STAB + 40, n);
			chk(32'(n >= STAB && n < STAB + 12), 32'h1, "fetch delay");
			chk({cpu_rst, per_rst, ints_dis, ports_in, pc_load}, 32'h0, "released");
			chk({rom_en, ext_cfg}, (k == 0) ? 32'h2 : 32'h0, "rom mode");
			rd8(crpc_pkg::IDX_STATUS, 32'h2, "run");
			rd8(crpc_pkg::IDX_CLK_CTL, 32'h0, "clk reset");
			rd8(crpc_pkg::IDX_STOP_CTL, 32'h0, "stop reset");
			wr8(crpc_pkg::IDX_CLK_CTL, 8'h18);
			wr8(crpc_pkg::IDX_STOP_CTL, 8'hA5);
		end
		// Divider ratios for every select code
		for (int i = 0; i < 4; i++)
		begin
			wr8(crpc_pkg::IDX_CLK_CTL, 8'(i << 3));
			repeat (2) wait_for(2, 40, n);
			wait_for(2, 40, n);
			chk(n, ratio[i], "cpu tick period");
		end
		// Unused bits, byte lanes and unmapped place
		wr8(crpc_pkg::IDX_CLK_CTL, 8'hFF);
		rd8(crpc_pkg::IDX_CLK_CTL, 32'h98, "clk mask");
		be <= 4'h0;
		wr8(crpc_pkg::IDX_CLK_CTL, 8'h00);
		be <= 4'hF;
		rd8(crpc_pkg::IDX_CLK_CTL, 32'h98, "lane off");
		wr8(8'hFF, 8'hFF);
		rd8(8'hFF, 32'h0, "unmapped");
		wr8(crpc_pkg::IDX_CLK_CTL, 8'h08);
		// Idle entry and interrupt exit
		op(crpc_pkg::OP_IDLE);
		rd8(crpc_pkg::IDX_STATUS, 32'h3, "idle");
		cnt(2, 40, c);
		chk(c, 0, "cpu gated");
		cnt(3, 40, c);
		chk(c, 5, "timers run");
		chk(cpu_rst, 0, "cpu kept");
		@(posedge mclk_i);
		irq_any <= 1'b1;
		wait_for(1, 10, n);
		chk(32'(n < 5), 32'h1, "idle wake");
		@(posedge mclk_i);
		irq_any <= 1'b0;
		rd8(crpc_pkg::IDX_STATUS, 32'h2, "idle left");
		rd8(crpc_pkg::IDX_CLK_CTL, 32'h08, "div kept");
		// Stop entry and wake from each line
		for (int w = 0; w < 2; w++)
		begin
			wr8(crpc_pkg::IDX_STOP_CTL, 8'h5A);
			op(crpc_pkg::OP_STOP);
			rd8(crpc_pkg::IDX_STATUS, 32'h4, "stop");
			chk(osc_run, 0, "osc off");
			cnt(3, 30, c);
			chk(c, 0, "all halted");
			@(posedge mclk_i);
			irq_any <= 1'b1;
			repeat (10) @(posedge mclk_i);
			irq_any <= 1'b0;
			rd8(crpc_pkg::IDX_STATUS, 32'h4, "no plain wake");
			crpc_pin_model_i.wake(w);
			@(negedge mclk_i);
			chk(wake_lv, 32'(1 << w), "wake level");
			wait_for(1, STAB + 40, n);
			chk(32'(n < STAB + 40), 32'h1, "stop wake");
			rd8(crpc_pkg::IDX_STATUS, 32'h2, "stop left");
			chk(osc_run, 32'h1, "osc back");
			rd8(crpc_pkg::IDX_CLK_CTL, 32'h08, "div kept");
			rd8(crpc_pkg::IDX_STOP_CTL, 32'h0, "stop ctl cleared");
		end
		close_out();
	end
endmodule : crpc_ctrl_tb

// ===== crpc_pin_model.sv
// Partner model of the pin side: reset pin driver, wake lines and test pin.
// Assumes the bench calls its tasks; every pin change follows a rising mclk_i edge.
`timescale 1ns/10ps
module crpc_pin_model #(
	parameter int HOLD_CYC = 20 // Shortest pin low time, scaled stabilisation time
) (
	// Clock
	input wire logic mclk_i,
	// Pins towards the controller
	output logic ext_reset_pin_low_n_o,
	output logic wake_irq_line_a_o,
	output logic wake_irq_line_b_o,
	output logic test_pin_o
);
	int low_cyc = 0; // Cycles the pin has been low

	// Idle levels: pin released, no wake, normal ROM mode
	initial
	begin
		ext_reset_pin_low_n_o = 1'b1;
		wake_irq_line_a_o = 1'b0;
		wake_irq_line_b_o = 1'b0;
		test_pin_o = 1'b0;
	end

	// Length of the current low phase
	always @(posedge mclk_i)
		low_cyc <= ext_reset_pin_low_n_o ? 0 : low_cyc + 1;

	// A release never comes before the pin was low long enough
	task pin_set(input logic level);
		@(posedge mclk_i);
		while (level && low_cyc < HOLD_CYC)
			@(posedge mclk_i);
		ext_reset_pin_low_n_o <= level;
	endtask : pin_set

	// Wake level long enough to pass the noise filter, then dropped
	task wake(input int line);
		@(posedge mclk_i);
		if (line == 0)
			wake_irq_line_a_o <= 1'b1;
		else
			wake_irq_line_b_o <= 1'b1;
		repeat (8) @(posedge mclk_i);
		wake_irq_line_a_o <= 1'b0;
		wake_irq_line_b_o <= 1'b0;
	endtask : wake

	// Test pin level, low selects normal ROM mode
	task test_set(input logic level);
		@(posedge mclk_i);
		test_pin_o <= level;
	endtask : test_set
endmodule : crpc_pin_model

// ===== crpc_pkg.sv
// Constants for the clock, reset and power-down controller.
// Assumes a 50 MHz oscillator clock and a 32-bit Avalon-MM register bus.
package crpc_pkg;
	// ----------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------
	localparam logic [7:0] IDX_CLK_CTL = 8'hD4; // Clock divider control
	localparam logic [7:0] IDX_STOP_CTL = 8'hD7; // Stop mode control
	localparam logic [7:0] IDX_STATUS = 8'hC0; // Controller status
	localparam int ADDR_W = 10; // Byte address width

	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam int CLK_DIV_LSB = 3; // Divider select low bit
	localparam int CLK_DIV_MSB = 4; // Divider select high bit
	localparam int CLK_TOP_BIT = 7; // Spare control bit
	localparam logic [7:0] CLK_CTL_MASK = 8'h98; // Implemented bits
	localparam logic [7:0] CLK_CTL_RST = 8'h00; // Reset value
	localparam logic [7:0] STOP_CTL_RST = 8'h00; // Reset value

	// ----------------------------------------
	// Divider select encodings and ratios
	// ----------------------------------------
	localparam logic [1:0] DIV_SEL_16 = 2'h0;
	localparam logic [1:0] DIV_SEL_8 = 2'h1;
	localparam logic [1:0] DIV_SEL_2 = 2'h2;
	localparam logic [1:0] DIV_SEL_1 = 2'h3;
	localparam logic [4:0] RATIO_16 = 5'h10;
	localparam logic [4:0] RATIO_8 = 5'h08;
	localparam logic [4:0] RATIO_2 = 5'h02;
	localparam logic [4:0] RATIO_1 = 5'h01;

	// ----------------------------------------
	// Opcodes and reset vector
	// ----------------------------------------
	localparam logic [7:0] OP_STOP = 8'h7F; // Enter Stop
	localparam logic [7:0] OP_IDLE = 8'h6F; // Enter Idle
	localparam logic [15:0] RESET_VECTOR = 16'h0100; // First fetch

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 50000000; // Oscillator rate
	localparam int STAB_TIME_US = 1000; // Stabilisation time in us
	localparam int STAB_CYC = (STAB_TIME_US * (CLK_HZ / 1000000)); // Cycles

	// ----------------------------------------
	// Controller states
	// ----------------------------------------
	typedef enum logic [2:0] {ST_RESET, ST_STAB, ST_RUN, ST_IDLE, ST_STOP} crpc_state_t;
endpackage : crpc_pkg
